// *** fpe_pkg.sv ***
// Constants for the array program, erase and block-protect controller
package fpe_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // Control register bit positions
  localparam int BIT_PGM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_MASS = 2;
  localparam int BIT_HIGH_VOLTAGE_ENABLE = 3;
  // Protection and array geometry
  localparam logic [15:0] PROT_LOC = 16'hffbe;
  localparam logic [7:0] BPR_OPEN = 8'hff;
  localparam logic [7:0] BPR_ALL_MAX = 8'h77;
  localparam logic [1:0] PROT_HI_BITS = 2'b11;
  localparam logic [5:0] PROT_LO_BITS = 6'h00;
  localparam int PAGE_LSB = 6;
  localparam int ROW_LSB = 5;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_LOADW = 3'b001,
    ST_IDLE = 3'b010,
    ST_SEL = 3'b011,
    ST_PRD = 3'b100,
    ST_LAT = 3'b101,
    ST_HV = 3'b110
  } fpe_state_t;
endpackage

// *** fpe_mem_if.sv ***
// Port between the controller and its byte array
`timescale 1ns/1ps
interface fpe_mem_if #(parameter int AW = 10);
  logic [AW-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

// *** fpe_array.sv ***
// Byte array with registered read data
`timescale 1ns/1ps
module fpe_array #(
  parameter int AW = 10
) (
  input wire logic clk_i,    // Bus clock
  fpe_mem_if.mem port        // Array access
);
  logic [7:0] mem_q [0:(1<<AW)-1];
  logic [7:0] rdata_q;

  // Delivered blank
  initial begin
    for (int i = 0; i < (1<<AW); i++) begin
      mem_q[i] = 8'hff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    rdata_q <= mem_q[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule

// *** fpe_ctrl.sv ***
// Program, erase and block-protect controller with AXI4-Lite registers
// Behaviour
// - High voltage set only after proper steps
// - High voltage enable drives pump and array
// - Program and erase selects never both set
// - Whole-array select makes erase cover everything
// - Page erase clears aligned 64 bytes
// - Whole-array erase refused while anything protected
// - Programming stays within one aligned 32-byte row
// - Program select enables address and data latching
// - Protected range to top blocks high voltage
// - Low values protect all, all-ones none
// - Protected area locked unless test voltage present
// - Start address built from protect bits
// - Protect register changes only by programming or erasing its array location
// - Erased bit reads one, programmed zero
`timescale 1ns/1ps
module fpe_ctrl
  import fpe_pkg::*;
#(
  parameter int AW = 10
) (
  input wire logic CLK_I,                 // Bus clock, 20 MHz
  input wire logic RST_N_I,               // Async reset, active low
  input wire logic TEST_HV_I,             // Test voltage present on interrupt pin
  output logic PUMP_ON_O,                 // Charge pump and array high voltage
  input wire logic [7:0] S_AXI_AWADDR,    // Write address
  input wire logic S_AXI_AWVALID,         // Write address valid
  output logic S_AXI_AWREADY,             // Write address ready
  input wire logic [31:0] S_AXI_WDATA,    // Write data
  input wire logic [3:0] S_AXI_WSTRB,     // Write strobes
  input wire logic S_AXI_WVALID,          // Write data valid
  output logic S_AXI_WREADY,              // Write data ready
  output logic [1:0] S_AXI_BRESP,         // Write response
  output logic S_AXI_BVALID,              // Write response valid
  input wire logic S_AXI_BREADY,          // Write response ready
  input wire logic [7:0] S_AXI_ARADDR,    // Read address
  input wire logic S_AXI_ARVALID,         // Read address valid
  output logic S_AXI_ARREADY,             // Read address ready
  output logic [31:0] S_AXI_RDATA,        // Read data
  output logic [1:0] S_AXI_RRESP,         // Read response
  output logic S_AXI_RVALID,              // Read data valid
  input wire logic S_AXI_RREADY           // Read data ready
);
  import fpe_pkg::*;

  localparam logic [AW:0] FULL_CNT = (AW+1)'(1 << AW);
  localparam logic [AW:0] PAGE_CNT = (AW+1)'(1 << PAGE_LSB);
  localparam logic [AW-1:0] PROT_IDX = PROT_LOC[AW-1:0];

  fpe_mem_if #(.AW(AW)) mem ();
  fpe_array #(.AW(AW)) u_array (.clk_i(CLK_I), .port(mem.mem));

  logic tst_meta_q, tst_q;
  fpe_state_t st_q, st_d;
  logic pgm_q, pgm_d, erase_q, erase_d, mass_q, mass_d, high_voltage_enable_q, high_voltage_enable_d;
  logic [7:0] bpr_q, bpr_d;
  logic [15:0] aaddr_q, aaddr_d, lat_q, lat_d;
  logic sweep_q, sweep_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [AW-1:0] sidx_q, sidx_d;
  logic bvalid_q, bvalid_d, rpend_q, rpend_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0] rsel_q, rsel_d;
  logic [31:0] rdata_q, rdata_d;

  logic ready, wr_fire, rd_fire, wr_ctrl, wr_data, wr_addr, rd_prot;
  logic in_range, prog_ok, hv_ok, lat_prot, wr_prot;
  logic [15:0] prot_start;
  logic [7:0] wctl;

  // Pin synchroniser
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tst_meta_q <= 1'b0;
      tst_q <= 1'b0;
    end else begin
      tst_meta_q <= TEST_HV_I;
      tst_q <= tst_meta_q;
    end
  end

  assign prot_start = {PROT_HI_BITS, bpr_q, PROT_LO_BITS};

  function automatic logic hit(input logic [15:0] a, input logic [7:0] b,
                               input logic [15:0] s, input logic t);
    hit = !t && (b != BPR_OPEN) && ((b <= BPR_ALL_MAX) || (a >= s));
  endfunction

  assign lat_prot = hit(lat_q, bpr_q, prot_start, tst_q);
  assign wr_prot = hit(aaddr_q, bpr_q, prot_start, tst_q);
  assign in_range = &aaddr_q[15:AW];

  // Bus handshakes
  assign ready = (st_q != ST_LOAD) && (st_q != ST_LOADW) && !sweep_q;
  assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q && ready;
  assign rd_fire = S_AXI_ARVALID && !rpend_q && !rvalid_q && !wr_fire && ready;
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY = wr_fire;
  assign S_AXI_ARREADY = rd_fire;
  assign wr_ctrl = wr_fire && (S_AXI_AWADDR == OFS_CTRL) && S_AXI_WSTRB[0];
  assign wr_addr = wr_fire && (S_AXI_AWADDR == OFS_ADDR);
  assign wr_data = wr_fire && (S_AXI_AWADDR == OFS_DATA) && S_AXI_WSTRB[0];
  assign rd_prot = rd_fire && (S_AXI_ARADDR == OFS_PROT);
  assign wctl = S_AXI_WDATA[7:0];

  // same row as the latched address
  assign prog_ok = pgm_q && high_voltage_enable_q && (st_q == ST_HV) && in_range && !wr_prot
                   && (aaddr_q[15:ROW_LSB] == lat_q[15:ROW_LSB]);

  // high voltage only after the step order
  assign hv_ok = (st_q == ST_LAT) && (pgm_q || erase_q) && !lat_prot
                 && !(erase_q && mass_q && (bpr_q != BPR_OPEN) && !tst_q);

  // Array port
  always_comb begin
    mem.addr = aaddr_q[AW-1:0];
    mem.we = 1'b0;
    mem.wdata = S_AXI_WDATA[7:0];
    if (sweep_q) begin
      mem.addr = sidx_q;
      mem.we = 1'b1;
      mem.wdata = ERASED_BYTE;
    end else if (st_q == ST_LOAD) begin
      mem.addr = PROT_IDX;
    end else if (wr_data) begin
      mem.we = prog_ok;
    end
  end

  // Control, sequence and sweep
  always_comb begin
    st_d = st_q;
    pgm_d = pgm_q;
    erase_d = erase_q;
    mass_d = mass_q;
    high_voltage_enable_d = high_voltage_enable_q;
    bpr_d = bpr_q;
    aaddr_d = aaddr_q;
    lat_d = lat_q;
    sweep_d = sweep_q;
    cnt_d = cnt_q;
    sidx_d = sidx_q;
    if (mem.we && (mem.addr == PROT_IDX)) begin
      // protect byte follows the array only
      bpr_d = mem.wdata;
    end
    if (wr_addr) begin
      if (S_AXI_WSTRB[0]) begin
        aaddr_d[7:0] = S_AXI_WDATA[7:0];
      end
      if (S_AXI_WSTRB[1]) begin
        aaddr_d[15:8] = S_AXI_WDATA[15:8];
      end
    end
    if (wr_ctrl) begin
      mass_d = wctl[BIT_MASS];
      // refuse a write asking for both selects
      if (!(wctl[BIT_PGM] && wctl[BIT_ERASE])) begin
        pgm_d = wctl[BIT_PGM];
        erase_d = wctl[BIT_ERASE];
      end
      // the enabling write must keep the latched selection
      high_voltage_enable_d = wctl[BIT_HIGH_VOLTAGE_ENABLE] && (high_voltage_enable_q || (hv_ok && (pgm_d == pgm_q)
               && (erase_d == erase_q) && (mass_d == mass_q)));
    end
    if (sweep_q) begin
      sidx_d = sidx_q + AW'(1);
      cnt_d = cnt_q - (AW+1)'(1);
      sweep_d = (cnt_q != (AW+1)'(1));
    end
    unique case (st_q)
      ST_LOAD: st_d = ST_LOADW;
      ST_LOADW: begin
        bpr_d = mem.rdata;
        st_d = ST_IDLE;
      end
      ST_IDLE: if (pgm_d || erase_d) st_d = ST_SEL;
      ST_SEL: if (rd_prot) st_d = ST_PRD;
      ST_PRD: if (wr_data) begin
        // any array address, protect location included
        lat_d = aaddr_q;
        st_d = ST_LAT;
      end
      ST_LAT: if (high_voltage_enable_d) begin
        st_d = ST_HV;
        if (erase_q) begin
          sweep_d = 1'b1;
          sidx_d = mass_q ? '0 : {lat_q[AW-1:PAGE_LSB], PROT_LO_BITS};
          cnt_d = mass_q ? FULL_CNT : PAGE_CNT;
        end
      end
      ST_HV: if (!high_voltage_enable_d) st_d = ST_IDLE;
    endcase
    if (!pgm_d && !erase_d && !high_voltage_enable_d && (st_q != ST_LOAD) && (st_q != ST_LOADW)) begin
      st_d = ST_IDLE;
    end
  end

  // Bus responses
  always_comb begin
    bvalid_d = bvalid_q && !S_AXI_BREADY;
    bresp_d = bresp_q;
    rpend_d = rd_fire;
    rsel_d = rd_fire ? S_AXI_ARADDR : rsel_q;
    rvalid_d = rvalid_q && !S_AXI_RREADY;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = ((S_AXI_AWADDR == OFS_CTRL) || (S_AXI_AWADDR == OFS_ADDR)
                 || (S_AXI_AWADDR == OFS_DATA)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rpend_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (rsel_q)
        OFS_CTRL: rdata_d = {28'h0000000, high_voltage_enable_q, mass_q, erase_q, pgm_q};
        OFS_PROT: rdata_d = {24'h000000, bpr_q};
        OFS_ADDR: rdata_d = {16'h0000, aaddr_q};
        OFS_DATA: rdata_d = {24'h000000, in_range ? mem.rdata : 8'h00};
        OFS_STAT: rdata_d = {24'h000000, 4'h0, sweep_q, st_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= ST_LOAD;
      pgm_q <= 1'b0;
      erase_q <= 1'b0;
      mass_q <= 1'b0;
      high_voltage_enable_q <= 1'b0;
      bpr_q <= 8'h00;
      aaddr_q <= 16'h0000;
      lat_q <= 16'h0000;
      sweep_q <= 1'b0;
      cnt_q <= '0;
      sidx_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rpend_q <= 1'b0;
      rsel_q <= 8'h00;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      pgm_q <= pgm_d;
      erase_q <= erase_d;
      mass_q <= mass_d;
      high_voltage_enable_q <= high_voltage_enable_d;
      bpr_q <= bpr_d;
      aaddr_q <= aaddr_d;
      lat_q <= lat_d;
      sweep_q <= sweep_d;
      cnt_q <= cnt_d;
      sidx_q <= sidx_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rpend_q <= rpend_d;
      rsel_q <= rsel_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign PUMP_ON_O = high_voltage_enable_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  hv_after_latch_a: assert property (
    $rose(high_voltage_enable_q) |-> $past(st_q) == ST_LAT) else $error("high voltage out of order");
  pump_needs_sel_a: assert property (
    $rose(PUMP_ON_O) |-> (pgm_q || erase_q)) else $error("pump on without select");
  sel_interlock_a: assert property (
    !(pgm_q && erase_q)) else $error("both selects set");
  mass_sweep_a: assert property (
    $rose(sweep_q) && mass_q |-> cnt_q == FULL_CNT && sidx_q == '0)
    else $error("whole erase range wrong");
  page_sweep_a: assert property (
    $rose(sweep_q) && !mass_q |-> cnt_q == PAGE_CNT && sidx_q[PAGE_LSB-1:0] == '0)
    else $error("page erase range wrong");
  mass_refuse_a: assert property (
    $rose(high_voltage_enable_q) && erase_q && mass_q |-> $past(bpr_q) == BPR_OPEN || $past(tst_q))
    else $error("whole erase while protected");
  row_bound_a: assert property (
    mem.we && !sweep_q |-> aaddr_q[15:ROW_LSB] == lat_q[15:ROW_LSB])
    else $error("program outside row");
  prog_latch_a: assert property (
    st_q == ST_PRD && wr_data |=> lat_q == $past(aaddr_q) && st_q != ST_PRD)
    else $error("address not latched");
  protect_block_a: assert property (
    $rose(high_voltage_enable_q) |-> !$past(lat_prot)) else $error("high voltage on protected block");
  prot_readonly_a: assert property (
    wr_fire && S_AXI_AWADDR == OFS_PROT |=> bpr_q == $past(bpr_q))
    else $error("protect byte changed by register write");
  erased_ones_a: assert property (
    sweep_q |-> mem.we && mem.wdata == ERASED_BYTE) else $error("erase not ones");
  idle_write_a: assert property (
    mem.we |-> sweep_q || (pgm_q && high_voltage_enable_q)) else $error("array changed without select");

  page_erase_c: cover property ($rose(sweep_q) && !mass_q);
  mass_erase_c: cover property ($rose(sweep_q) && mass_q);
  program_c: cover property (mem.we && !sweep_q);
  refused_hv_c: cover property (wr_ctrl && wctl[BIT_HIGH_VOLTAGE_ENABLE] && st_q == ST_LAT && !hv_ok);
endmodule

// *** fpe_tb.sv ***
// Self-checking testbench for the program, erase and block-protect controller
`timescale 1ns/1ps
module testbench;
  import fpe_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic test_hv = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pump, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] v;
  int n_mismatch = 0;
  int comparisons = 0;

  fpe_ctrl #(.AW(10)) dut (.CLK_I(clk), .RST_N_I(rst_n), .TEST_HV_I(test_hv), .PUMP_ON_O(pump),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  always #25 clk = ~clk;

  task finish_test;
    $display("Counts: mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data offered together, response awaited with bready up
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, e});
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, e});
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task peek(input logic [15:0] a, input logic [7:0] e);
    wr(OFS_ADDR, {16'h0, a}, RESP_OKAY);
    rd(OFS_DATA, v, RESP_OKAY);
    chk(v, {24'h0, e});
  endtask

  // Single-byte program in the latched row; a write one row up must not land
  task prog(input logic [15:0] a, input logic [7:0] d, input logic ok);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    rd(OFS_PROT, v, RESP_OKAY);
    wr(OFS_ADDR, {16'h0, a[15:5], 5'h00}, RESP_OKAY);
    wr(OFS_DATA, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h9, RESP_OKAY);
    chk({31'h0, pump}, {31'h0, ok});
    // one byte follows, then the next-row write, each as separate bus writes
    wr(OFS_ADDR, {16'h0, a}, RESP_OKAY);
    wr(OFS_DATA, {24'h0, d}, RESP_OKAY);
    wr(OFS_ADDR, {16'h0, a + 16'h0020}, RESP_OKAY);
    wr(OFS_DATA, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h8, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    chk({31'h0, pump}, 32'h0);
  endtask

  task erase(input logic [15:0] a, input logic m, input logic ok);
    wr(OFS_CTRL, m ? 32'h6 : 32'h2, RESP_OKAY);
    rd(OFS_PROT, v, RESP_OKAY);
    wr(OFS_ADDR, {16'h0, a}, RESP_OKAY);
    wr(OFS_DATA, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, m ? 32'he : 32'ha, RESP_OKAY);
    chk({31'h0, pump}, {31'h0, ok});
    wr(OFS_CTRL, 32'h8, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
  endtask

  task t_regs;
    rd(OFS_CTRL, v, RESP_OKAY);
    chk(v, 32'h0);
    rd(OFS_PROT, v, RESP_OKAY);
    chk(v, {24'h0, BPR_OPEN});
    wr(OFS_PROT, 32'h12, RESP_SLVERR);
    rd(OFS_PROT, v, RESP_OKAY);
    chk(v, {24'h0, BPR_OPEN});
    rd(8'h14, v, RESP_SLVERR);
    chk(v, 32'h0);
    rd(OFS_STAT, v, RESP_OKAY);
    chk(v, {24'h0, 4'h0, 1'b0, ST_IDLE});
    chk({31'h0, pump}, 32'h0);
  endtask

  task t_interlock;
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    rd(OFS_CTRL, v, RESP_OKAY);
    chk(v & 32'h3, 32'h0);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    rd(OFS_CTRL, v, RESP_OKAY);
    chk(v & 32'h3, 32'h1);
    wr(OFS_CTRL, 32'h2, RESP_OKAY);
    rd(OFS_CTRL, v, RESP_OKAY);
    chk(v & 32'h3, 32'h2);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
  endtask

  task t_hv_gate;
    wr(OFS_CTRL, 32'h8, RESP_OKAY);
    rd(OFS_CTRL, v, RESP_OKAY);
    chk(v & 32'h8, 32'h0);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wr(OFS_CTRL, 32'h9, RESP_OKAY);
    chk({31'h0, pump}, 32'h0);
    rd(OFS_PROT, v, RESP_OKAY);
    wr(OFS_DATA, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h8, RESP_OKAY);
    chk({31'h0, pump}, 32'h0);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
  endtask

  task t_program;
    wr(OFS_ADDR, 32'hfc00, RESP_OKAY);
    rd(OFS_ADDR, v, RESP_OKAY);
    chk(v, 32'hfc00);
    wr(OFS_DATA, 32'h0, RESP_OKAY);
    peek(16'hfc00, ERASED_BYTE);
    // each byte programmed once per erase
    prog(16'hfc05, 8'h5a, 1'b1);
    peek(16'hfc05, 8'h5a);
    peek(16'hfc00, ERASED_BYTE);
    peek(16'hfc25, ERASED_BYTE);
  endtask

  task t_erase;
    prog(16'hfc45, 8'h33, 1'b1);
    erase(16'hfc10, 1'b0, 1'b1);
    peek(16'hfc05, ERASED_BYTE);
    peek(16'hfc45, 8'h33);
  endtask

  task t_protect;
    logic [15:0] st;
    st = {PROT_HI_BITS, 8'hfe, PROT_LO_BITS};
    prog(PROT_LOC, 8'hfe, 1'b1);
    rd(OFS_PROT, v, RESP_OKAY);
    chk(v, 32'hfe);
    prog(st, 8'h11, 1'b0);
    peek(st, ERASED_BYTE);
    prog(st - 16'h1, 8'h22, 1'b1);
    peek(st - 16'h1, 8'h22);
    prog(PROT_LOC, 8'h00, 1'b0);
    erase(16'hfc00, 1'b1, 1'b0);
    peek(st - 16'h1, 8'h22);
    test_hv <= 1'b1;
    repeat (5) @(posedge clk);
    // latch write aimed at the protect location
    erase(PROT_LOC, 1'b1, 1'b1);
    peek(st - 16'h1, ERASED_BYTE);
    rd(OFS_PROT, v, RESP_OKAY);
    chk(v, {24'h0, BPR_OPEN});
    test_hv <= 1'b0;
    repeat (5) @(posedge clk);
    prog(PROT_LOC, BPR_ALL_MAX, 1'b1);
    prog(16'hfc00, 8'h44, 1'b0);
    peek(16'hfc00, ERASED_BYTE);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_interlock();
    t_hv_gate();
    t_program();
    t_erase();
    t_protect();
    finish_test();
  end

  // One whole-array sweep, one page sweep and register traffic fit well inside this span
  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
endmodule
